//--- src/gpc_port.sv
/*
 Port C block: eight pin GPIO port with special functions, edge interrupts and the
 interrupt enable and status registers.
 Assumes one 10 MHz clock, a plain one-cycle register port, external logic for the
 serial channels and memory controller, and a pad that resolves the enables.
*/
`timescale 1ns/1ns
// How it works
// - mode byte picks GPIO or special function
// - direction byte picks input or output
// - data read returns live pin state, latched pending on armed edge pins
// - data write drives only GPIO outputs
// - low pins detect falling or rising edges
// - edge latches pending, write one clears
// - pending bits feed interrupt sources
// - re-raise only on new edge
// - serial output driven inverted on pad
// - ring indicator pins inverted to status
// - pin 6 drives active-low interrupt request
// - pin 5 input: slave enable or clock
// - pin 5 output: enable, clock, or output
// - pin 3 carries DRAM address mux
// - enable register read and write whole
// - set address sets written ones
// - clear address clears written ones
// - set address reads masked status
// - clear address reads raw status
// - writing zero leaves pending unchanged
// - edge sources sit in bits 3..0
module gpc_port import gpc_pkg::*; #(
   parameter int PINS = GPC_PINS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [GPC_AW-1:0] addr,
   input wire logic [GPC_DW-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [GPC_DW-1:0] rdata,
   // pins
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe,
   // serial channels
   input wire gpc_chan_t chan_a,
   input wire gpc_chan_t chan_b,
   output gpc_chan_in_t chan_a_in,
   output gpc_chan_in_t chan_b_in,
   // memory controller
   input wire logic dram_addr_mux_bit,
   input wire logic dram_addr_mux_bit_b,
   input wire logic dram_mux_level,
   // other interrupt sources, bits 31..4
   input wire logic [GPC_DW-1:0] other_sources,
   // processor request
   output logic irq
);
   // field layout and pin roles are fixed at eight pins
   if (PINS != GPC_PINS) begin : g_pins_check
      $error("gpc_port serves exactly eight pins");
   end

   function automatic logic [GPC_DW-1:0] set_clr(input logic [GPC_DW-1:0] cur,
                                                  input logic [GPC_DW-1:0] s,
                                                  input logic [GPC_DW-1:0] c);
      set_clr = (cur | s) & ~c;
   endfunction

   logic [7:0] mode_ff;
   logic [7:0] dir_ff;
   logic [3:0] secondary_mode_field_ff;
   logic [7:0] data_ff;
   logic [GPC_DW-1:0] ien_ff;
   logic [GPC_DW-1:0] rdata_ff;
   logic [7:0] sync1_ff;
   logic [7:0] sync2_ff;
   logic [GPC_EDGE_PINS-1:0] pending;

   // two flops on every pin before any logic reads it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end

   // address decode
   wire sel_port = (addr == GPC_ADDR_PORT);
   wire sel_ien = (addr == GPC_ADDR_IEN);
   wire sel_iset = (addr == GPC_ADDR_ISET);
   wire sel_iclr = (addr == GPC_ADDR_ICLR);
   wire wr_port = wr & sel_port;

   // pin roles
   wire [7:0] gpio_out = ~mode_ff & dir_ff;
   wire [7:0] sf_in = mode_ff & ~dir_ff;
   wire [7:0] sf_out = mode_ff & dir_ff;

   // data byte only takes writes on GPIO output pins
   wire [7:0] wr_data = wdata[GPC_DATA_LSB +: 8];
   wire [7:0] nxt_data = wr_port ? ((wr_data & gpio_out) | (data_ff & ~gpio_out)) : data_ff;

   // write-one acknowledge on edge pins in special function mode
   wire [GPC_EDGE_PINS-1:0] ack = {GPC_EDGE_PINS{wr_port}} & wr_data[GPC_EDGE_PINS-1:0] &
                                  mode_ff[GPC_EDGE_PINS-1:0];

   gpc_edge_det #(.N(GPC_EDGE_PINS)) u_edge (
      .clk(clk),
      .reset(reset),
      .level(sync2_ff[GPC_EDGE_PINS-1:0]),
      .arm(mode_ff[GPC_EDGE_PINS-1:0]),
      .rising(dir_ff[GPC_EDGE_PINS-1:0]),
      .ack(ack),
      .pending(pending)
   );

   // interrupt sources: edge pending bits in the low positions
   wire [GPC_DW-1:0] raw_src = {other_sources[GPC_DW-1:GPC_EDGE_PINS], pending};
   wire [GPC_DW-1:0] masked_src = raw_src & ien_ff;
   wire irq_w = |masked_src;

   // enable register: whole write, set and clear personalities
   wire [GPC_DW-1:0] ien_set = (wr & sel_iset) ? wdata : '0;
   wire [GPC_DW-1:0] ien_clr = (wr & sel_iclr) ? wdata : '0;
   wire [GPC_DW-1:0] nxt_ien = (wr & sel_ien) ? wdata : set_clr(ien_ff, ien_set, ien_clr);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_ff <= GPC_MODE_RST;
         dir_ff <= GPC_DIR_RST;
         secondary_mode_field_ff <= GPC_SECONDARY_MODE_FIELD_RST;
         data_ff <= GPC_DATA_RST;
         ien_ff <= GPC_IEN_RST;
      end else begin
         if (wr_port) begin
            mode_ff <= wdata[GPC_MODE_LSB +: 8];
            dir_ff <= wdata[GPC_DIR_LSB +: 8];
            // stored as written; nonzero values are software's fault
            secondary_mode_field_ff <= wdata[GPC_SECONDARY_MODE_FIELD_LSB +: 4];
         end
         data_ff <= nxt_data;
         ien_ff <= nxt_ien;
      end
   end

   // data byte read: live pin level, latched pending on armed edge pins
   wire [7:0] pend_view = {4'h0, pending};
   wire [7:0] edge_mask = {4'h0, mode_ff[GPC_EDGE_PINS-1:0]};
   wire [7:0] data_view = (sync2_ff & ~edge_mask) | (pend_view & edge_mask);
   wire [GPC_DW-1:0] port_view = {mode_ff, dir_ff, 4'h0, secondary_mode_field_ff, data_view};

   wire [GPC_DW-1:0] nxt_rdata = !rd ? '0 :
                                 sel_port ? port_view :
                                 sel_ien ? ien_ff :
                                 sel_iset ? masked_src :
                                 sel_iclr ? raw_src : '0;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign rdata = rdata_ff;
   assign irq = irq_w;

   // special function outputs, pad levels
   // pin 7/5: master enable, else clock, else inverted serial output
   function automatic logic chan_pad(input gpc_chan_t c);
      if (c.spi_master) begin
         chan_pad = ~c.spi_master;
      end else if (c.transmit_clock_export_bit) begin
         chan_pad = c.transmit_clock;
      end else begin
         chan_pad = ~c.serial_gp_output;
      end
   endfunction

   // pin 3 goes over to the memory controller when either mux bit asks
   wire dram_own = dram_addr_mux_bit | dram_addr_mux_bit_b;

   wire [7:0] sf_level = {chan_pad(chan_a), ~irq_w, chan_pad(chan_b), 5'h00};
   wire [7:0] sf_drive = sf_out & 8'hE0;
   wire [7:0] oe_w = gpio_out | sf_drive;
   wire [7:0] out_w = (data_ff & gpio_out) | (sf_level & sf_drive);

   always_comb begin
      pin_out = out_w;
      pin_oe = oe_w;
      if (dram_own) begin
         pin_out[GPC_PIN_DRAM] = dram_mux_level;
         pin_oe[GPC_PIN_DRAM] = 1'b1;
      end
   end

   // special function inputs: active-low ring and enable pads to active-high status, clock pads passed uninverted
   wire ria = sf_in[GPC_PIN_RIA_IRQ] & ~sync2_ff[GPC_PIN_RIA_IRQ];
   wire rib = sf_in[GPC_PIN_RIB] & ~sync2_ff[GPC_PIN_RIB];
   wire sea = sf_in[GPC_PIN_CHA] & chan_a.spi_slave & ~sync2_ff[GPC_PIN_CHA];
   wire seb = sf_in[GPC_PIN_CHB] & chan_b.spi_slave & ~sync2_ff[GPC_PIN_CHB];
   wire cka = sf_in[GPC_PIN_CHA] & chan_a.transmit_clock_source_bit & sync2_ff[GPC_PIN_CHA];
   wire ckb = sf_in[GPC_PIN_CHB] & chan_b.transmit_clock_source_bit & sync2_ff[GPC_PIN_CHB];

   assign chan_a_in = '{ring_indicator: ria, slave_enable: sea, ext_transmit_clock: cka};
   assign chan_b_in = '{ring_indicator: rib, slave_enable: seb, ext_transmit_clock: ckb};
endmodule

//--- src/gpc_pkg.sv
/*
 Package for the port C block: register addresses, field positions, reset values,
 pin role indices and the carrier structs shared by the port and its bench.
 Assumes a plain register port with word addresses given as byte addresses.
*/
package gpc_pkg;
   localparam int GPC_AW = 32;
   localparam int GPC_DW = 32;
   localparam int GPC_PINS = 8;
   localparam int GPC_EDGE_PINS = 4;
   // port C register sits at the same byte address as the example write shows
   localparam logic [31:0] GPC_ADDR_PORT = 32'hFFB00028;
   localparam logic [31:0] GPC_ADDR_IEN = 32'hFFB00030;
   localparam logic [31:0] GPC_ADDR_ISET = 32'hFFB00034;
   localparam logic [31:0] GPC_ADDR_ICLR = 32'hFFB00038;
   localparam int GPC_MODE_LSB = 24;
   localparam int GPC_DIR_LSB = 16;
   localparam int GPC_SECONDARY_MODE_FIELD_LSB = 8;
   localparam int GPC_DATA_LSB = 0;
   localparam logic [7:0] GPC_MODE_RST = 8'h00;
   localparam logic [7:0] GPC_DIR_RST = 8'h00;
   localparam logic [3:0] GPC_SECONDARY_MODE_FIELD_RST = 4'h0;
   localparam logic [7:0] GPC_DATA_RST = 8'h00;
   localparam logic [31:0] GPC_IEN_RST = 32'h00000000;
   localparam int GPC_PIN_DRAM = 3;
   localparam int GPC_PIN_RIB = 4;
   localparam int GPC_PIN_CHB = 5;
   localparam int GPC_PIN_RIA_IRQ = 6;
   localparam int GPC_PIN_CHA = 7;

   // serial channel controls that steer a shared pin
   typedef struct packed {
      logic spi_master;
      logic spi_slave;
      logic transmit_clock_source_bit;
      logic transmit_clock_export_bit;
      logic transmit_clock;
      logic serial_gp_output;
   } gpc_chan_t;

   // serial channel view of the port pins, all active high
   typedef struct packed {
      logic ring_indicator;
      logic slave_enable;
      logic ext_transmit_clock;
   } gpc_chan_in_t;

   // pin group: input, output, output enable
   typedef struct packed {
      logic [7:0] din;
      logic [7:0] dout;
      logic [7:0] oe;
   } gpc_pins_t;
endpackage

//--- src/gpc_edge_det.sv
/*
 Edge detector with latched pending bits for the low port pins.
 Assumes inputs already synchronised to clk by the caller.
*/
`timescale 1ns/1ns
module gpc_edge_det import gpc_pkg::*; #(
   parameter int N = GPC_EDGE_PINS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // pin view
   input wire logic [N-1:0] level,
   input wire logic [N-1:0] arm,
   input wire logic [N-1:0] rising,
   // software acknowledge, one cycle
   input wire logic [N-1:0] ack,
   // pending state
   output logic [N-1:0] pending
);
   logic [N-1:0] prev_ff;
   logic [N-1:0] pend_ff;
   wire [N-1:0] rise_w = level & ~prev_ff;
   wire [N-1:0] fall_w = ~level & prev_ff;
   // only a transition sets, so a steady level after ack stays clear
   wire [N-1:0] hit_w = arm & ((rising & rise_w) | (~rising & fall_w));
   // a new edge wins over an ack in the same cycle; zero ack bits change nothing
   wire [N-1:0] nxt_pend = hit_w | (pend_ff & ~ack);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prev_ff <= '0;
         pend_ff <= '0;
      end else begin
         prev_ff <= level;
         pend_ff <= nxt_pend;
      end
   end
   assign pending = pend_ff;
endmodule

//--- sim/gpc_port_checker.sv
/*
 Assertions on the port C block: enable registers, status reads, pins.
 Bound to every gpc_port instance; sees its ports only.
*/
`timescale 1ns/1ns
module gpc_port_checker import gpc_pkg::*; #(
   parameter int PINS = GPC_PINS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [GPC_AW-1:0] addr,
   input wire logic [GPC_DW-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [GPC_DW-1:0] rdata,
   // pins and sources
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe,
   input wire logic dram_addr_mux_bit,
   input wire logic dram_addr_mux_bit_b,
   input wire logic dram_mux_level,
   input wire logic [GPC_DW-1:0] other_sources,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire w_ien = wr && addr == GPC_ADDR_IEN;
   wire r_ien = rd && addr == GPC_ADDR_IEN;
   wire w_set = wr && addr == GPC_ADDR_ISET;
   wire w_clr = wr && addr == GPC_ADDR_ICLR;
   wire r_raw = rd && addr == GPC_ADDR_ICLR;
   wire r_msk = rd && addr == GPC_ADDR_ISET;
   wire r_port = rd && addr == GPC_ADDR_PORT;
   wire dram_on = dram_addr_mux_bit || dram_addr_mux_bit_b;
   chk_en_readback: assert property (w_ien ##1 r_ien |=> rdata == $past(wdata, 2))
      else $error("enable readback differs from write");
   chk_en_set: assert property (w_set ##1 r_ien |=> (rdata & $past(wdata, 2)) == $past(wdata, 2))
      else $error("set write left an enable bit low");
   chk_en_clear: assert property (w_clr ##1 r_ien |=> (rdata & $past(wdata, 2)) == 32'h0)
      else $error("clear write left an enable bit high");
   chk_raw_status: assert property (r_raw |=> rdata[31:4] == $past(other_sources[31:4]))
      else $error("raw status differs from sources");
   chk_irq_masked: assert property (r_msk |=> (|rdata) == $past(irq))
      else $error("request disagrees with masked status");
   // sync flops are cleared by reset, so skip reads too close to it
   chk_live_read: assert property ((r_port && !$past(reset) && !$past(reset, 2))
      |=> rdata[7:4] == $past(pin_in[7:4], 3))
      else $error("data read is not the synchronised pin");
   chk_gpio_hold: assert property (!$past(wr) |-> $stable(pin_oe[2:0]) && $stable(pin_out[2:0] & pin_oe[2:0]))
      else $error("low pins changed without a write");
   chk_dram_pin: assert property (dram_on |-> pin_oe[3] && pin_out[3] == dram_mux_level)
      else $error("pin 3 not carrying the address mux level");
   cover property (w_ien ##1 r_ien);
   cover property ($rose(irq));
   cover property (dram_on && pin_oe[3]);
   cover property (r_port ##1 (rdata[3:0] != 4'h0));
endmodule

bind gpc_port gpc_port_checker #(.PINS(PINS)) gpc_port_checker_inst (.clk(clk), .reset(reset), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .dram_addr_mux_bit(dram_addr_mux_bit), .dram_addr_mux_bit_b(dram_addr_mux_bit_b),
   .dram_mux_level(dram_mux_level), .other_sources(other_sources), .irq(irq));

//--- sim/gpc_pad_model.sv
/*
 Pads and peripherals on the port C pins.
 Each pad follows the block while it drives, else the bench's peripheral level.
*/
`timescale 1ns/1ns
module gpc_pad_model (
   // block side
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // peripheral levels and resolved pads
   input wire logic [7:0] ext,
   output logic [7:0] pin_in
);
   // a driven pad reads back its own level, as a real pad does
   assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule

//--- sim/gpc_port_tb.sv
/*
 Self-checking bench for the port C block: registers, pin modes, edge pending bits.
 Assumes the checker is bound in and the pad model resolves the pins.
*/
`timescale 1ns/1ns
module gpc_port_tb import gpc_pkg::*;;
   logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, dam = 1'b0, dam_b = 1'b0, dml = 1'b0, irq;
   logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, osrc = 32'h0, r, lf = 32'h46, exp_en;
   logic [7:0] pout, poe, pin, ext = 8'h00;
   gpc_chan_t cha = 6'h00, chb = 6'h00;
   gpc_chan_in_t cha_in, chb_in;
   int num_errors = 0, check_count = 0;
   gpc_port gpc_port_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .pin_in(pin), .pin_out(pout), .pin_oe(poe), .chan_a(cha), .chan_b(chb), .chan_a_in(cha_in),
      .chan_b_in(chb_in), .dram_addr_mux_bit(dam), .dram_addr_mux_bit_b(dam_b), .dram_mux_level(dml),
      .other_sources(osrc), .irq(irq));
   gpc_pad_model gpc_pad_model_inst (.pin_out(pout), .pin_oe(poe), .ext(ext), .pin_in(pin));
   initial begin
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] lfsr_step(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic exp_irq(input logic [31:0] raw, input logic [31:0] en);
      return |(raw & en);
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // every strobe is assigned once per call, so back-to-back calls never race
   task automatic acc(input logic w, input logic rr, input logic [31:0] a, input logic [31:0] d);
      wr <= w;
      rd <= rr;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask
   // rdata stands one cycle after the strobe: take it mid-cycle, then rejoin the edge
   task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
      acc(1'b0, 1'b1, a, 32'h0);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      repeat (n) acc(1'b0, 1'b0, 32'h0, 32'h0);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      idle(4);
      rd_reg(GPC_ADDR_IEN, r);
      check("enable reset", r, GPC_IEN_RST);
      rd_reg(GPC_ADDR_PORT, r);
      check("port reset", r, {GPC_MODE_RST, GPC_DIR_RST, 4'h0, GPC_SECONDARY_MODE_FIELD_RST, GPC_DATA_RST});
      rd_reg(32'hFFB0003C, r);
      check("unmapped", r, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         osrc <= lf;
         lf = lfsr_step(lf);
         acc(1'b1, 1'b0, GPC_ADDR_IEN, lf);
         exp_en = lf;
         rd_reg(GPC_ADDR_IEN, r);
         check("enable", r, exp_en);
         lf = lfsr_step(lf);
         acc(1'b1, 1'b0, GPC_ADDR_ISET, lf);
         exp_en = exp_en | lf;
         rd_reg(GPC_ADDR_IEN, r);
         check("enable set", r, exp_en);
         lf = lfsr_step(lf);
         acc(1'b1, 1'b0, GPC_ADDR_ICLR, lf);
         exp_en = exp_en & ~lf;
         rd_reg(GPC_ADDR_IEN, r);
         check("enable clear", r, exp_en);
         rd_reg(GPC_ADDR_ICLR, r);
         check("raw status", r, {osrc[31:4], 4'h0});
         rd_reg(GPC_ADDR_ISET, r);
         check("masked status", r, {osrc[31:4], 4'h0} & exp_en);
         check("irq", {31'h0, irq}, {31'h0, exp_irq({osrc[31:4], 4'h0}, exp_en)});
      end
      $display("enable test done");
      lf = lfsr_step(lf);
      // data written while the pins are still inputs is dropped
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'h00, 8'hFF, 8'h00, lf[7:0]});
      idle(1);
      check("input write", {16'h0, poe, pout}, {16'h0, 8'hFF, GPC_DATA_RST});
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'h00, 8'hFF, 8'h00, lf[7:0]});
      idle(3);
      check("gpio drive", {16'h0, poe, pout}, {16'h0, 8'hFF, lf[7:0]});
      rd_reg(GPC_ADDR_PORT, r);
      check("gpio read", r, {8'h00, 8'hFF, 8'h00, lf[7:0]});
      ext <= lf[15:8];
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'h00, 8'h0F, 8'h00, ~lf[7:0]});
      idle(3);
      rd_reg(GPC_ADDR_PORT, r);
      check("dir split", {poe, r[7:0]}, {8'h0F, lf[15:12], ~lf[3:0]});
      $display("gpio test done");
      cha <= {5'h00, lf[16]};
      chb <= {3'h0, 1'b1, lf[17], 1'b0};
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'hE0, 8'hE0, 8'h00, 8'hFF});
      idle(2);
      r = {26'h0, 3'h7, ~lf[16], ~exp_irq({osrc[31:4], 4'h0}, exp_en), lf[17]};
      check("sf out", {poe[7:5], pout[7:5]}, r);
      chb <= 6'h20;
      idle(1);
      check("master enable", {31'h0, pout[5]}, 32'h0);
      cha <= 6'h10;
      chb <= 6'h18;
      ext <= {1'b0, 1'b0, lf[18], 1'b1, 4'h0};
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'hF0, 8'h00, 8'h00, 8'h00});
      idle(3);
      check("sf in", {cha_in, chb_in}, {3'b110, 1'b0, ~lf[18], lf[18]});
      $display("special function test done");
      osrc <= 32'h0;
      ext <= 8'h05;
      acc(1'b1, 1'b0, GPC_ADDR_IEN, 32'h0000000F);
      idle(3);
      // pins settle before arming, so no stray edge is latched
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'h0F, 8'h0A, 8'h00, 8'h00});
      idle(3);
      ext <= 8'h0A;
      idle(4);
      rd_reg(GPC_ADDR_PORT, r);
      check("pending", r[3:0], 4'hF);
      rd_reg(GPC_ADDR_ICLR, r);
      check("edge sources", {irq, r[3:0]}, 5'h1F);
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'h0F, 8'h0A, 8'h00, 8'h00});
      rd_reg(GPC_ADDR_PORT, r);
      check("zero write", r[3:0], 4'hF);
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'h0F, 8'h0A, 8'h00, 8'h05});
      ext <= 8'h05;
      idle(4);
      rd_reg(GPC_ADDR_PORT, r);
      check("ack and wrong edges", r[3:0], 4'hA);
      acc(1'b1, 1'b0, GPC_ADDR_PORT, {8'h0F, 8'h0A, 8'h00, 8'h0A});
      ext <= 8'h0A;
      idle(4);
      rd_reg(GPC_ADDR_PORT, r);
      check("new edges", r[3:0], 4'hF);
      $display("edge test done");
      dam <= 1'b1;
      dml <= lf[19];
      idle(1);
      check("dram a", {poe[3], pout[3]}, {1'b1, lf[19]});
      dam <= 1'b0;
      dam_b <= 1'b1;
      dml <= ~lf[19];
      idle(1);
      check("dram b", {poe[3], pout[3]}, {1'b1, ~lf[19]});
      $display("dram test done");
      report_and_stop();
   end
endmodule
